// [cas_pkg.sv]
// shared constants for the per-channel signalling block
package cas_pkg;

  // register offsets on the plain register port
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h01;
  localparam logic [4:0] OFS_DISC_MS = 5'h02;
  localparam logic [4:0] OFS_GUARD_MS = 5'h03;
  localparam logic [4:0] OFS_PAT_WR = 5'h04;
  localparam logic [4:0] OFS_ENABLES = 5'h05;
  localparam logic [4:0] OFS_PAT_BASE = 5'h10;

  // control register fields
  localparam int CTRL_SELF_CLEAR = 0;
  localparam int CTRL_SIMPLE = 1;
  localparam int CTRL_MODE_TABLE = 2;
  localparam int CTRL_D4 = 3;
  localparam int CTRL_DISC_SUP = 4;
  localparam int CTRL_ALARM_CLR = 5;
  localparam int CTRL_COND_OFFHOOK = 6;
  localparam int CTRL_BLOCK_OFFHOOK = 7;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // pattern write register fields: index, count, bits
  localparam int PW_BITS_LSB = 0;
  localparam int PW_CNT_LSB = 4;
  localparam int PW_IDX_LSB = 8;

  // optional-state enable fields and reset value
  localparam int EN_BLOCK = 0;
  localparam int EN_SEIZE_ACK = 1;
  localparam logic [1:0] EN_RESET = 2'h2;

  // timer limits in ms
  localparam logic [11:0] DISC_MAX_MS = 12'hFA0;
  localparam logic [11:0] GUARD_MAX_MS = 12'h7D0;
  localparam logic [11:0] DISC_RESET_MS = 12'h3E8;
  localparam logic [11:0] GUARD_RESET_MS = 12'h000;

  // pattern table indices
  localparam int NPAT = 14;
  localparam logic [3:0] P_IDLE_TX = 4'h0;
  localparam logic [3:0] P_IDLE_RX = 4'h1;
  localparam logic [3:0] P_BLOCK_RX = 4'h2;
  localparam logic [3:0] P_RING_ON = 4'h3;
  localparam logic [3:0] P_RING_OFF = 4'h4;
  localparam logic [3:0] P_IN_OFFHOOK = 4'h5;
  localparam logic [3:0] P_CONNECTED = 4'h6;
  localparam logic [3:0] P_DISC_TX = 4'h7;
  localparam logic [3:0] P_DISC_RX = 4'h8;
  localparam logic [3:0] P_SEIZE_RX = 4'h9;
  localparam logic [3:0] P_SEIZE_ACK = 4'hA;
  localparam logic [3:0] P_MAKE_RX = 4'hB;
  localparam logic [3:0] P_BREAK_RX = 4'hC;
  localparam logic [3:0] P_ANSWERED = 4'hD;

  // built-in default patterns, one nibble per index; make and answered differ
  // from disconnect receive and connected so that each state is recognisable
  localparam logic [55:0] DEFAULT_PATS = 56'hA5_AF5F_5F50_5F01;

  // call states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GUARD = 3'b001,
    ST_RING = 3'b010,
    ST_CONN = 3'b011,
    ST_DIAL = 3'b100,
    ST_DISC = 3'b101,
    ST_WAIT_IDLE = 3'b110,
    ST_BLOCKED = 3'b111
  } call_state_e;

endpackage

// [cas_call_signaling.sv]
// per-channel channel-associated signalling engine with alarm clearing control
// Operation
// RULE1: self-clear drops alarm when condition ends
// RULE2: without self-clear, alarm held until cleared
// RULE3: line processing and yellow stop on clear
// RULE4: non-simple teardown waits for customer idle
// RULE5: simple teardown idles right after disconnect
// RULE6: mode default or table; default reloads patterns
// RULE7: two-bit entry copies AB into CD
// RULE8: other bit counts rejected, pattern kept
// RULE9: D4 framing ignores C and D bits
// RULE10: idle sends idle pattern, recognises idle
// RULE11: optional blocking state reports chosen hook
// RULE12: ringer on and off follow cadence
// RULE13: incoming offhook answers, sends connected
// RULE14: far release sends disconnect; customer ends
// RULE15: seize starts outgoing, optional acknowledge
// RULE16: dial make and break recognised
// RULE17: far answer sends answered pattern
// RULE18: disconnect held programmable ms, ignores reconnect
// RULE19: disconnect timer only far-end, supervised
// RULE20: release guard holds idle, ignores requests
// RULE21: customer waits out release guard
// RULE22: four-bit patterns, optional states enable flags
// RULE23: conditioning presents all on or off-hook
`timescale 1ns/1ps
module cas_call_signaling
  import cas_pkg::*;
#(
  parameter int CLK_HZ = 25_000_000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // millisecond tick from the same clock
  input wire logic msTick,
  // customer-side abcd bits from the link, asynchronous
  input wire logic [3:0] rxAbcd,
  output logic [3:0] txAbcd,
  // host switch requests and reports, same clock
  input wire logic hostRingOn,
  input wire logic hostRingCadence,
  input wire logic hostFarAnswer,
  input wire logic hostFarRelease,
  input wire logic alarmCond,
  output logic hostOffHook,
  output logic dialBreak,
  output logic callAnswered,
  // alarm outputs
  output logic alarmActive,
  output logic yellowSend,
  output logic lineCond
);

  // elaboration check: the ms timer needs at least a kilohertz clock
  if (CLK_HZ < 1000) begin : g_clkCheck
    $error("clock too slow for ms timing");
  end

  ////////////////////////////////////////////////////////////////////
  // input synchroniser for the link bits
  // only the second stage feeds logic; the first may go metastable
  logic [3:0] rxMeta_ff; // first stage
  logic [3:0] rxSync_ff; // second stage

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxMeta_ff <= 4'h0;
      rxSync_ff <= 4'h0;
    end else begin
      rxMeta_ff <= rxAbcd;
      rxSync_ff <= rxMeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] ctrl_ff; // control bits
  logic [1:0] enables_ff; // optional state enables
  logic [11:0] discMs_ff; // disconnect time
  logic [11:0] guardMs_ff; // release guard time
  logic [3:0] pats_ff [NPAT]; // pattern table
  logic patReject_ff; // last entry refused

  wire wrCtrl = regWrite && regAddr == OFS_CTRL;
  wire wrPat = regWrite && regAddr == OFS_PAT_WR;
  wire [3:0] pwIdx = regWrData[PW_IDX_LSB +: 4];
  wire [3:0] pwCnt = regWrData[PW_CNT_LSB +: 4];
  wire [3:0] pwBits = regWrData[PW_BITS_LSB +: 4];
  wire selDefault = wrCtrl && !regWrData[CTRL_MODE_TABLE];

  // control, timer and enable registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
      enables_ff <= EN_RESET;
      discMs_ff <= DISC_RESET_MS;
      guardMs_ff <= GUARD_RESET_MS;
    end else begin
      if (wrCtrl) ctrl_ff <= regWrData[7:0] & ~(8'h01 << CTRL_ALARM_CLR);
      // timer values clamp at their maxima
      if (regWrite && regAddr == OFS_DISC_MS) begin
        discMs_ff <= (regWrData[11:0] > DISC_MAX_MS) ? DISC_MAX_MS : regWrData[11:0]; // [RULE18]
      end
      if (regWrite && regAddr == OFS_GUARD_MS) begin
        guardMs_ff <= (regWrData[11:0] > GUARD_MAX_MS) ? GUARD_MAX_MS : regWrData[11:0]; // [RULE20]
      end
      if (regWrite && regAddr == OFS_ENABLES) enables_ff <= regWrData[1:0]; // [RULE22]
    end
  end

  // pattern table: defaults on reset or a control write with the table mode bit clear, entries in table mode
  always_ff @(posedge clk) begin
    if (!rst_n || selDefault) begin
      for (int i = 0; i < NPAT; i++) pats_ff[i] <= DEFAULT_PATS[4*i +: 4]; // [RULE6]
      patReject_ff <= 1'b0;
    end else if (wrPat && ctrl_ff[CTRL_MODE_TABLE] && int'(pwIdx) < NPAT) begin
      if (pwCnt == 4'h2) begin
        pats_ff[pwIdx] <= {pwBits[3:2], pwBits[3:2]}; // [RULE7]
        patReject_ff <= 1'b0;
      end else if (pwCnt == 4'h4) begin
        pats_ff[pwIdx] <= pwBits; // [RULE22]
        patReject_ff <= 1'b0;
      end else begin
        patReject_ff <= 1'b1; // [RULE8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pattern match, D4 compares A and B only
  function automatic logic patMatch(input logic [3:0] rx, input logic [3:0] pat,
                                    input logic d4);
    patMatch = d4 ? (rx[3:2] == pat[3:2]) : (rx == pat); // [RULE9]
  endfunction

  wire d4 = ctrl_ff[CTRL_D4];
  wire rxIdle = patMatch(rxSync_ff, pats_ff[P_IDLE_RX], d4);
  wire rxBlock = enables_ff[EN_BLOCK] && patMatch(rxSync_ff, pats_ff[P_BLOCK_RX], d4);
  wire rxInOff = patMatch(rxSync_ff, pats_ff[P_IN_OFFHOOK], d4);
  wire rxDisc = patMatch(rxSync_ff, pats_ff[P_DISC_RX], d4);
  wire rxSeize = patMatch(rxSync_ff, pats_ff[P_SEIZE_RX], d4);
  wire rxMake = patMatch(rxSync_ff, pats_ff[P_MAKE_RX], d4);
  wire rxBreak = patMatch(rxSync_ff, pats_ff[P_BREAK_RX], d4);

  ////////////////////////////////////////////////////////////////////
  // alarm indication and line conditioning
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarmActive <= 1'b0;
      lineCond <= 1'b0;
      yellowSend <= 1'b0;
    end else begin
      lineCond <= alarmCond; // [RULE3]
      yellowSend <= alarmCond; // [RULE3]
      if (alarmCond) alarmActive <= 1'b1;
      else if (ctrl_ff[CTRL_SELF_CLEAR]) alarmActive <= 1'b0; // [RULE1]
      else if (wrCtrl && regWrData[CTRL_ALARM_CLR]) alarmActive <= 1'b0; // [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // call state machine
  call_state_e state_ff, nxt_state;
  logic [11:0] msCnt_ff; // timer in ms
  logic outgoing_ff; // call was started by the customer
  logic [11:0] nxt_msCnt;
  logic nxt_outgoing;

  always_comb begin
    nxt_state = state_ff;
    nxt_msCnt = msCnt_ff;
    nxt_outgoing = outgoing_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (rxBlock) begin
          nxt_state = ST_BLOCKED; // [RULE11]
        end else if (hostRingOn) begin
          nxt_state = ST_RING;
          nxt_outgoing = 1'b0;
        end else if (rxSeize) begin
          nxt_state = ST_DIAL; // [RULE15]
          nxt_outgoing = 1'b1;
        end
      end
      ST_GUARD: begin
        // requests ignored until guard expires
        if (msCnt_ff == 12'h000) nxt_state = ST_IDLE; // [RULE20]
        else if (msTick) nxt_msCnt = msCnt_ff - 12'h001;
      end
      ST_BLOCKED: begin
        if (!rxBlock) nxt_state = ST_IDLE;
      end
      ST_RING: begin
        if (rxInOff) nxt_state = ST_CONN; // [RULE13]
        else if (!hostRingOn) nxt_state = ST_IDLE;
      end
      ST_DIAL: begin
        if (hostFarAnswer) nxt_state = ST_CONN; // [RULE17]
        else if (rxIdle || rxDisc) begin
          nxt_state = ST_GUARD;
          nxt_msCnt = guardMs_ff;
        end
      end
      ST_CONN: begin
        if (hostFarRelease) begin
          nxt_state = ST_DISC; // [RULE14]
          nxt_msCnt = ctrl_ff[CTRL_DISC_SUP] ? discMs_ff : 12'h000; // [RULE19]
        end else if (rxDisc) begin
          nxt_state = ST_GUARD; // [RULE14]
          nxt_msCnt = guardMs_ff;
        end
      end
      ST_DISC: begin
        // reconnect from the customer is ignored here
        if (msCnt_ff == 12'h000) begin
          if (ctrl_ff[CTRL_SIMPLE]) begin
            nxt_state = ST_GUARD; // [RULE5]
            nxt_msCnt = guardMs_ff;
          end else begin
            nxt_state = ST_WAIT_IDLE; // [RULE4]
          end
        end else if (msTick) begin
          nxt_msCnt = msCnt_ff - 12'h001; // [RULE18]
        end
      end
      ST_WAIT_IDLE: begin
        if (rxIdle) begin
          nxt_state = ST_GUARD; // [RULE4]
          nxt_msCnt = guardMs_ff;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      msCnt_ff <= 12'h000;
      outgoing_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      msCnt_ff <= nxt_msCnt;
      outgoing_ff <= nxt_outgoing;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmit pattern selection
  // d4 has no c and d bits, so those are sent as zeros
  logic [3:0] nxt_tx;
  always_comb begin
    nxt_tx = pats_ff[P_IDLE_TX]; // [RULE10]
    unique case (state_ff)
      ST_RING: nxt_tx = hostRingCadence ? pats_ff[P_RING_ON] : pats_ff[P_RING_OFF]; // [RULE12]
      ST_CONN: nxt_tx = outgoing_ff ? pats_ff[P_ANSWERED] : pats_ff[P_CONNECTED]; // [RULE13]
      ST_DIAL: begin
        if (enables_ff[EN_SEIZE_ACK]) nxt_tx = pats_ff[P_SEIZE_ACK]; // [RULE15]
      end
      ST_DISC, ST_WAIT_IDLE: nxt_tx = pats_ff[P_DISC_TX]; // [RULE14]
      default: nxt_tx = pats_ff[P_IDLE_TX];
    endcase
    if (d4) nxt_tx[1:0] = 2'b00; // [RULE9]
  end

  // host-facing hook report and line outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txAbcd <= 4'h0;
      hostOffHook <= 1'b0;
      dialBreak <= 1'b0;
      callAnswered <= 1'b0;
    end else begin
      txAbcd <= nxt_tx;
      dialBreak <= (state_ff == ST_DIAL) && rxBreak && !rxMake; // [RULE16]
      callAnswered <= (state_ff == ST_CONN);
      if (lineCond) hostOffHook <= ctrl_ff[CTRL_COND_OFFHOOK]; // [RULE23]
      else if (state_ff == ST_BLOCKED) hostOffHook <= ctrl_ff[CTRL_BLOCK_OFFHOOK]; // [RULE11]
      else hostOffHook <= state_ff inside {ST_CONN, ST_DIAL, ST_WAIT_IDLE};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      if (regAddr == OFS_CTRL) regRdData <= {8'h00, ctrl_ff};
      else if (regAddr == OFS_STATUS) begin
        regRdData <= {4'h0, patReject_ff, alarmActive, lineCond, outgoing_ff,
                      rxSync_ff, 1'b0, state_ff};
      end
      else if (regAddr == OFS_DISC_MS) regRdData <= {4'h0, discMs_ff};
      else if (regAddr == OFS_GUARD_MS) regRdData <= {4'h0, guardMs_ff};
      else if (regAddr == OFS_ENABLES) regRdData <= {14'h0000, enables_ff};
      else if (regAddr >= OFS_PAT_BASE && int'(regAddr - OFS_PAT_BASE) < NPAT) begin
        regRdData <= {12'h000, pats_ff[regAddr[3:0]]};
      end
      else regRdData <= 16'h0000;
    end else begin
      regRdData <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_selfclear;
    @(posedge clk) disable iff (!rst_n)
    (!alarmCond && ctrl_ff[CTRL_SELF_CLEAR] && alarmActive) |=> !alarmActive;
  endproperty
  a_selfclear: assert property (p_selfclear) else $error("alarm not self-cleared"); // [RULE1]

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    (alarmActive && !ctrl_ff[CTRL_SELF_CLEAR] && !alarmCond && !wrCtrl) |=> alarmActive;
  endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped without clear"); // [RULE2]

  property p_yellow;
    @(posedge clk) disable iff (!rst_n)
    !alarmCond |=> !yellowSend && !lineCond;
  endproperty
  a_yellow: assert property (p_yellow) else $error("yellow kept after clear"); // [RULE3]

  property p_simple;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == ST_DISC && msCnt_ff == 12'h000 && ctrl_ff[CTRL_SIMPLE]) |=> state_ff == ST_GUARD;
  endproperty
  a_simple: assert property (p_simple) else $error("simple teardown not idle"); // [RULE5]

  property p_wait;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == ST_WAIT_IDLE && !rxIdle) |=> state_ff == ST_WAIT_IDLE;
  endproperty
  a_wait: assert property (p_wait) else $error("left wait before idle"); // [RULE4]

  property p_reject;
    @(posedge clk) disable iff (!rst_n)
    // an index beyond the table is ignored, not refused
    (wrPat && ctrl_ff[CTRL_MODE_TABLE] && int'(pwIdx) < NPAT && pwCnt != 4'h2
      && pwCnt != 4'h4 && !selDefault) |=> patReject_ff;
  endproperty
  a_reject: assert property (p_reject) else $error("bad count accepted"); // [RULE8]

  property p_guard;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == ST_GUARD && msCnt_ff != 12'h000) |=> state_ff == ST_GUARD;
  endproperty
  a_guard: assert property (p_guard) else $error("guard left early"); // [RULE20]

  property p_disc;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == ST_DISC && msCnt_ff != 12'h000) |=> state_ff == ST_DISC;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect cut short"); // [RULE18]

  property p_cond;
    @(posedge clk) disable iff (!rst_n)
    lineCond |=> hostOffHook == $past(ctrl_ff[CTRL_COND_OFFHOOK]);
  endproperty
  a_cond: assert property (p_cond) else $error("conditioning hook wrong"); // [RULE23]

endmodule

// [cpe_model.sv]
// customer equipment model driving abcd bits toward the block
`timescale 1ns/1ps
module cpe_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pattern the customer wants to show, and its reaction delay
  input wire logic [3:0] want,
  input wire logic [3:0] lag,
  // abcd bits toward the block
  output logic [3:0] rxAbcd
);
  logic [3:0] pend_ff; // pattern waiting to be shown
  logic [3:0] cnt_ff; // cycles left before it shows
  ////////////////////////////////////////////////////////////////
  // delayed follow of the wanted pattern, prompt or slow
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_ff <= want;
      cnt_ff <= 4'h0;
      rxAbcd <= want;
    end else if (want !== pend_ff) begin
      pend_ff <= want;
      cnt_ff <= lag;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else begin
      rxAbcd <= pend_ff; // show the pending pattern once its delay has run out
    end
  end
endmodule

// [cas_call_signaling_test.sv]
// self-checking bench for the per-channel signalling block
`timescale 1ns/1ps
module cas_call_signaling_test;
  import cas_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [4:0] regAddr = 0;
  logic [15:0] regWrData = 0;
  logic regWrite = 0;
  logic regRead = 0;
  logic [15:0] regRdData;
  logic msTick = 0;
  logic [3:0] rxAbcd, txAbcd;
  logic hostRingOn = 0, hostRingCadence = 0, hostFarAnswer = 0, hostFarRelease = 0;
  logic alarmCond = 0;
  logic hostOffHook, dialBreak, callAnswered, alarmActive, yellowSend, lineCond;
  logic [3:0] want = DEFAULT_PATS[7:4]; // idle receive pattern
  logic [3:0] lag = 4'h0;
  logic [3:0] tickCnt = 0;
  logic rdPend = 0;
  logic [15:0] expQ[$]; // expected read data, oldest first
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [3:0] b, c;
  int seed;
  ////////////////////////////////////////////////////////////////
  // clock, ms tick every ten cycles, run limit
  always #20 clk = ~clk;
  always @(posedge clk) begin
    tickCnt <= (tickCnt == 4'h9) ? 4'h0 : tickCnt + 4'h1;
    msTick <= (tickCnt == 4'h9);
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  cas_call_signaling u_cas_call_signaling (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .msTick(msTick), .rxAbcd(rxAbcd), .txAbcd(txAbcd), .hostRingOn(hostRingOn),
    .hostRingCadence(hostRingCadence), .hostFarAnswer(hostFarAnswer),
    .hostFarRelease(hostFarRelease), .alarmCond(alarmCond), .hostOffHook(hostOffHook),
    .dialBreak(dialBreak), .callAnswered(callAnswered), .alarmActive(alarmActive),
    .yellowSend(yellowSend), .lineCond(lineCond));
  cpe_model u_cpe_model (.clk(clk), .rst_n(rst_n), .want(want), .lag(lag), .rxAbcd(rxAbcd));
  ////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [3:0] dp(input logic [3:0] i);
    return DEFAULT_PATS[4*i +: 4];
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // read data compared one cycle after the strobe
  always @(posedge clk) begin
    rdPend <= regRead;
    if (rdPend && expQ.size() > 0) begin
      chk("regRdData", expQ.pop_front(), regRdData);
    end
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitTx(input logic [3:0] e, input int bound);
    for (int k = 0; k < bound && txAbcd !== e; k++) @(posedge clk);
    chk("txAbcd", {12'h0, e}, {12'h0, txAbcd});
  endtask
  task automatic pulse(input int which);
    if (which == 0) hostFarRelease <= 1'b1;
    else hostFarAnswer <= 1'b1;
    @(posedge clk);
    hostFarRelease <= 1'b0;
    hostFarAnswer <= 1'b0;
    @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = $urandom(88186);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL, {8'h00, CTRL_RESET});
    rd(OFS_DISC_MS, {4'h0, DISC_RESET_MS});
    rd(OFS_GUARD_MS, {4'h0, GUARD_RESET_MS});
    rd(OFS_ENABLES, {14'h0, EN_RESET});
    rd(5'h1F, 16'h0000);
    for (int i = 0; i < NPAT; i++) rd(5'(OFS_PAT_BASE + i), {12'h0, dp(4'(i))});
    // table entries: two-bit copy, bad count kept, reload on default
    wr(OFS_CTRL, 16'h0007);
    b = 4'($urandom);
    c = 4'($urandom_range(5, 15));
    wr(OFS_PAT_WR, {4'h0, P_RING_ON, 4'h2, b});
    rd(OFS_PAT_BASE + P_RING_ON, {12'h0, b[3:2], b[3:2]});
    wr(OFS_PAT_WR, {4'h0, P_RING_ON, c, ~b});
    rd(OFS_PAT_BASE + P_RING_ON, {12'h0, b[3:2], b[3:2]});
    wr(OFS_PAT_WR, {4'h0, P_RING_ON, 4'h4, b});
    rd(OFS_PAT_BASE + P_RING_ON, {12'h0, b});
    wr(OFS_CTRL, 16'h0003);
    rd(OFS_PAT_BASE + P_RING_ON, {12'h0, dp(P_RING_ON)});
    // d4 framing drops c and d
    wr(OFS_CTRL, 16'h000B);
    waitTx({dp(P_IDLE_TX) & 4'hC}, 10);
    wr(OFS_CTRL, 16'h0013);
    waitTx(dp(P_IDLE_TX), 10);
    // optional blocking state reports off-hook when chosen
    wr(OFS_ENABLES, 16'h0003);
    wr(OFS_CTRL, 16'h0093);
    want <= dp(P_BLOCK_RX);
    repeat (8) @(posedge clk);
    chk("hostOffHook", 16'h1, {15'h0, hostOffHook});
    want <= dp(P_IDLE_RX);
    wr(OFS_ENABLES, 16'h0002);
    repeat (8) @(posedge clk);
    chk("hostOffHook", 16'h0, {15'h0, hostOffHook});
    // incoming call, simple teardown, supervised disconnect of 3 ms
    wr(OFS_DISC_MS, 16'h0003);
    wr(OFS_GUARD_MS, 16'h0002);
    lag <= 4'h5;
    hostRingOn <= 1'b1;
    hostRingCadence <= 1'b1;
    waitTx(dp(P_RING_ON), 10);
    hostRingCadence <= 1'b0;
    waitTx(dp(P_RING_OFF), 10);
    want <= dp(P_IN_OFFHOOK);
    waitTx(dp(P_CONNECTED), 20);
    chk("callAnswered", 16'h1, {15'h0, callAnswered});
    hostRingOn <= 1'b0;
    pulse(0);
    waitTx(dp(P_DISC_TX), 10);
    repeat (18) @(posedge clk);
    chk("txAbcd", {12'h0, dp(P_DISC_TX)}, {12'h0, txAbcd});
    waitTx(dp(P_IDLE_TX), 30);
    want <= dp(P_IDLE_RX);
    hostRingOn <= 1'b1;
    hostRingCadence <= 1'b1;
    repeat (5) @(posedge clk);
    chk("txAbcd", {12'h0, dp(P_IDLE_TX)}, {12'h0, txAbcd});
    waitTx(dp(P_RING_ON), 40);
    // same again without simple teardown: waits for customer idle
    want <= dp(P_IN_OFFHOOK);
    waitTx(dp(P_CONNECTED), 20);
    hostRingOn <= 1'b0;
    wr(OFS_CTRL, 16'h0011);
    pulse(0);
    waitTx(dp(P_DISC_TX), 10);
    repeat (60) @(posedge clk);
    chk("txAbcd", {12'h0, dp(P_DISC_TX)}, {12'h0, txAbcd});
    want <= dp(P_IDLE_RX);
    waitTx(dp(P_IDLE_TX), 30);
    // outgoing call after the guard has run out
    repeat (40) @(posedge clk);
    lag <= 4'h0;
    want <= dp(P_SEIZE_RX);
    waitTx(dp(P_SEIZE_ACK), 10);
    want <= dp(P_BREAK_RX);
    repeat (6) @(posedge clk);
    chk("dialBreak", 16'h1, {15'h0, dialBreak});
    want <= dp(P_MAKE_RX);
    repeat (6) @(posedge clk);
    chk("dialBreak", 16'h0, {15'h0, dialBreak});
    pulse(1);
    waitTx(dp(P_ANSWERED), 10);
    // alarms: self clear, conditioning hook, held alarm and manual clear
    wr(OFS_CTRL, 16'h0043);
    alarmCond <= 1'b1;
    repeat (4) @(posedge clk);
    chk("lineCond", 16'h1, {15'h0, lineCond});
    chk("hostOffHook", 16'h1, {15'h0, hostOffHook});
    alarmCond <= 1'b0;
    repeat (4) @(posedge clk);
    chk("alarmActive", 16'h0, {15'h0, alarmActive});
    wr(OFS_CTRL, 16'h0002);
    alarmCond <= 1'b1;
    repeat (4) @(posedge clk);
    chk("yellowSend", 16'h1, {15'h0, yellowSend});
    chk("hostOffHook", 16'h0, {15'h0, hostOffHook});
    alarmCond <= 1'b0;
    repeat (4) @(posedge clk);
    chk("alarmActive", 16'h1, {15'h0, alarmActive});
    chk("yellowSend", 16'h0, {15'h0, yellowSend});
    wr(OFS_CTRL, 16'h0022);
    repeat (2) @(posedge clk);
    chk("alarmActive", 16'h0, {15'h0, alarmActive});
    conclude();
  end
endmodule
